// ---- dv/psic_irq_cmd_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module psic_irq_cmd_checker #(parameter int NMOD = 8, parameter int SW = 2) (
	// clock, reset, register port
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire psic_pkg::psic_bus_s bus,
	input wire logic [31:0] rdata,
	// events, states, irq
	input wire psic_pkg::psic_emu_s emuEvent,
	input wire logic [NMOD*SW-1:0] nextState,
	input wire logic [NMOD*SW-1:0] curState,
	input wire logic domainBusy,
	input wire logic power_ctrl_irq
);
	import psic_pkg::*;
	wire rdPend = ce && bus.rd && bus.addr == OFS_ERRPEND;
	wire rdWo = ce && bus.rd && (bus.addr == OFS_REEVAL || bus.addr == OFS_XCMD);
	wire wrEval = ce && bus.wr && bus.addr == OFS_REEVAL && bus.wdata[BIT_REEVAL];
	wire wrCmd = ce && bus.wr && bus.addr == OFS_XCMD && !domainBusy;
	wire clrErr = ce && bus.wr && bus.addr == OFS_ERRCLR && bus.wdata[BIT_ERR39];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_pend_reserved: assert property (rdPend |=> rdata[31:8] == 24'h0 && rdata[6:0] == 7'h0)
		else $error("pending reserved bits set");
	a_wo_read_zero: assert property (rdWo |=> rdata == 32'h0)
		else $error("write-only register read nonzero");
	a_clr_drops_pend: assert property ((emuEvent == 2'h0)[*6] ##0 clrErr ##[1:2]
		(rdPend && emuEvent == 2'h0) |=> !rdata[BIT_ERR39]) else $error("pending survived clear");
	a_zero_no_go: assert property (wrCmd && !bus.wdata[BIT_GO] |=> !domainBusy)
		else $error("zero started transition");
	a_go_busy: assert property (wrCmd && bus.wdata[BIT_GO] |=> domainBusy)
		else $error("go did not start transition");
	a_busy_ends: assert property ($rose(domainBusy) |-> ##[1:200] !domainBusy)
		else $error("transition never ended");
	a_cur_in_busy: assert property ($changed(curState) |-> $past(domainBusy))
		else $error("state moved outside transition");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> rdata == 32'h0 && !domainBusy)
		else $error("outputs not cleared by reset");
	a_eval_drops_irq: assert property (wrEval |=> !power_ctrl_irq)
		else $error("irq not re-armed on reevaluate");
endmodule
bind psic_irq_cmd psic_irq_cmd_checker #(.NMOD(NMOD), .SW(SW)) chk (.clk(clk), .rst(rst),
	.ce(ce), .bus(bus), .rdata(rdata), .emuEvent(emuEvent), .nextState(nextState),
	.curState(curState), .domainBusy(domainBusy), .power_ctrl_irq(power_ctrl_irq));
`default_nettype wire

// ---- dv/psic_irq_cmd_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module psic_irq_cmd_tb;
	import psic_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	psic_bus_s bus = '0;
	psic_emu_s emuEvent = '0;
	logic [15:0] nextState = 16'h0009;
	logic [31:0] rdata;
	logic [15:0] curState;
	logic domainBusy;
	logic power_ctrl_irq;
	int num_errors = 0;
	int checks = 0;
	logic [11:0] zeroRegs [6] = '{OFS_ERRPEND, OFS_REEVAL, OFS_ERRCLR, OFS_XCMD, OFS_XSTAT, 12'h3FC};
	psic_irq_cmd dut (.clk(clk), .rst(rst), .ce(1'b1), .bus(bus), .rdata(rdata),
		.emuEvent(emuEvent), .nextState(nextState), .curState(curState),
		.domainBusy(domainBusy), .power_ctrl_irq(power_ctrl_irq));
	initial forever #12.5 clk = ~clk;
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk) bus.rd <= 1'b0;
		#1 chk($sformatf("reg %h", a), rdata, e);
	endtask
	task automatic waitIrq(input logic e);
		for (int i = 0; i < 12 && power_ctrl_irq !== e; i++) @(posedge clk);
		#1 chk("irq", {31'h0, power_ctrl_irq}, {31'h0, e});
	endtask
	task automatic waitIdle(input logic [31:0] e);
		#1;
		for (int i = 0; i < 200 && domainBusy !== 1'b0; i++) @(posedge clk);
		#1 chk("curState", {16'h0, curState}, e);
	endtask
	task automatic close_out;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		close_out();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wr(OFS_ERRPEND, 32'hFFFF_FFFF);
		foreach (zeroRegs[i]) rd(zeroRegs[i], 32'h0);
		wr(OFS_CPUCTL, 32'h3);
		@(posedge clk) emuEvent <= '{1'b0, 1'b1};
		waitIrq(1'b1);
		@(posedge clk) emuEvent <= '0;
		repeat (6) @(posedge clk);
		rd(OFS_ERRPEND, 32'h80);
		rd(OFS_CPUSTAT, 32'h1);
		wr(OFS_ERRCLR, 32'hFFFF_FF7F);
		rd(OFS_ERRPEND, 32'h80);
		wr(OFS_REEVAL, 32'h1);
		waitIrq(1'b1);
		wr(OFS_ERRCLR, 32'h80);
		rd(OFS_ERRPEND, 32'h0);
		rd(OFS_CPUSTAT, 32'h0);
		rd(OFS_IRQSTAT, 32'h1);
		waitIrq(1'b0);
		wr(OFS_CPUCTL, 32'h0);
		@(posedge clk) emuEvent <= '{1'b1, 1'b0};
		repeat (10) @(posedge clk);
		waitIrq(1'b0);
		@(posedge clk) emuEvent <= '0;
		repeat (6) @(posedge clk);
		wr(OFS_ERRCLR, 32'h80);
		wr(OFS_IRQMASK, 32'h2);
		wr(OFS_XCMD, 32'h0);
		rd(OFS_XSTAT, 32'h0);
		wr(OFS_XCMD, 32'h1);
		rd(OFS_XSTAT, 32'h1);
		waitIdle(32'h9);
		waitIrq(1'b1);
		rd(OFS_IRQSTAT, 32'h2);
		waitIrq(1'b0);
		wr(OFS_XCMD, 32'h1);
		waitIdle(32'h9);
		close_out();
	end
endmodule
`default_nettype wire

// ---- rtl/psic_irq_cmd.sv ----
// Contract
// - reevaluate write of one re-checks interrupt
// - writing zero to command bits: no action
// - command bits write-only, zero after reset
// - pending bit 7 shows module 39 error
// - only module 39 errors; others read zero
// - pending register read-only, reset zero
// - clear bit 7 clears pending and flags
// - go examines all next-state fields
// - mismatching modules move; matching ones stay
// - irq high while enabled event active; here it drops two cycles after delivery until reevaluate or a new event
// - reevaluate re-asserts irq if events remain
// - events gated by module 39 enables
// - busy bit reads one during transition
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module psic_irq_cmd #(
	parameter int NMOD = 8,
	parameter int SW = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire psic_pkg::psic_bus_s bus,
	output logic [31:0] rdata,
	// emulation events (pins from outside the clock domain)
	input wire psic_pkg::psic_emu_s emuEvent,
	// module state fields
	input wire logic [NMOD*SW-1:0] nextState,
	output logic [NMOD*SW-1:0] curState,
	output logic domainBusy,
	// interrupt to the processor
	output logic power_ctrl_irq
);
	import psic_pkg::*;

	typedef enum {IDLE, SCAN, WAIT} psic_state_e;

	psic_emu_s emuMeta, emuSync;
	logic [1:0] cpuCtl;
	logic resetFlag, stateFlag, errPend;
	logic [1:0] irqStat, irqMask;
	logic evalPend;
	psic_state_e st;
	logic [$clog2(NMOD+1)-1:0] idx;
	logic [$clog2(STEP_CYCLES+1)-1:0] stepCnt;

	wire wrEval = bus.wr && hit(bus.addr, OFS_REEVAL) && bus.wdata[BIT_REEVAL];
	wire wrClr = bus.wr && hit(bus.addr, OFS_ERRCLR) && bus.wdata[BIT_ERR39];
	wire wrGo = bus.wr && hit(bus.addr, OFS_XCMD) && bus.wdata[BIT_GO];
	wire wrCtl = bus.wr && hit(bus.addr, OFS_CPUCTL);
	wire wrMask = bus.wr && hit(bus.addr, OFS_IRQMASK);
	wire rdIrq = bus.rd && hit(bus.addr, OFS_IRQSTAT);
	wire newRst = emuSync.resetAltered && cpuCtl[BIT_RST_EN];
	wire newState = emuSync.stateAltered && cpuCtl[BIT_STATE_EN];
	wire newErr = newRst || newState;
	wire doneEv = (st == WAIT) && (stepCnt == 0) && (idx == NMOD[$bits(idx)-1:0] - 1'b1);
	wire anyEvent = resetFlag || stateFlag || errPend;
	// line held low one cycle on reevaluate so an edge-sensing controller sees it again
	wire next_irq = ((anyEvent && !evalPend) || |(irqStat & irqMask)) && !wrEval;
	wire [SW-1:0] nxtField = nextState[idx[$clog2(NMOD)-1:0]*SW +: SW];
	wire [SW-1:0] curField = curState[idx[$clog2(NMOD)-1:0]*SW +: SW];
	wire mism = nxtField != curField;

	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = RST_ZERO;
		if (bus.rd) begin
			unique case (bus.addr)
				OFS_ERRPEND: next_rdata[BIT_ERR39] = errPend;
				OFS_XSTAT: next_rdata[BIT_BUSY] = domainBusy;
				OFS_CPUCTL: next_rdata[1:0] = cpuCtl;
				OFS_CPUSTAT: next_rdata[1:0] = {stateFlag, resetFlag};
				OFS_IRQSTAT: next_rdata[1:0] = irqStat;
				OFS_IRQMASK: next_rdata[1:0] = irqMask;
				default: next_rdata = RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			emuMeta <= '0;
			emuSync <= '0;
		end else if (ce) begin
			emuMeta <= emuEvent;
			emuSync <= emuMeta;
		end
	end

	// flags: set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			resetFlag <= 1'b0;
			stateFlag <= 1'b0;
			errPend <= 1'b0;
			cpuCtl <= 2'h0;
			irqMask <= RST_MASK;
			irqStat <= 2'h0;
			evalPend <= 1'b0;
			rdata <= RST_ZERO;
			power_ctrl_irq <= 1'b0;
		end else if (ce) begin
			resetFlag <= newRst || (resetFlag && !wrClr);
			stateFlag <= newState || (stateFlag && !wrClr);
			errPend <= newErr || (errPend && !wrClr);
			if (wrCtl)
				cpuCtl <= bus.wdata[1:0];
			if (wrMask)
				irqMask <= bus.wdata[1:0];
			irqStat[IRQ_ERR] <= newErr || (irqStat[IRQ_ERR] && !rdIrq);
			irqStat[IRQ_DONE] <= doneEv || (irqStat[IRQ_DONE] && !rdIrq);
			// after delivery, wait for reevaluate unless a new event arrives
			if (newErr || wrEval)
				evalPend <= 1'b0;
			else if (power_ctrl_irq && anyEvent)
				evalPend <= 1'b1;
			rdata <= next_rdata;
			power_ctrl_irq <= next_irq;
		end
	end

	// transition engine walks every module of the domain
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= IDLE;
			idx <= '0;
			stepCnt <= '0;
			curState <= '0;
			domainBusy <= 1'b0;
		end else if (ce) begin
			unique case (st)
				IDLE: if (wrGo) begin
					st <= SCAN;
					idx <= '0;
					domainBusy <= 1'b1;
				end
				SCAN: begin
					stepCnt <= mism ? STEP_CYCLES[$bits(stepCnt)-1:0] : '0;
					st <= WAIT;
				end
				WAIT: if (stepCnt != 0) begin
					stepCnt <= stepCnt - 1'b1;
					if (stepCnt == 1)
						curState[idx[$clog2(NMOD)-1:0]*SW +: SW] <= nxtField;
				end else if (idx == NMOD[$bits(idx)-1:0] - 1'b1) begin
					st <= IDLE;
					domainBusy <= 1'b0;
				end else begin
					idx <= idx + 1'b1;
					st <= SCAN;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- rtl/psic_pkg.sv ----
package psic_pkg;
	// register offsets (byte addresses)
	localparam logic [11:0] OFS_REEVAL = 12'h018;
	localparam logic [11:0] OFS_ERRPEND = 12'h044;
	localparam logic [11:0] OFS_ERRCLR = 12'h054;
	localparam logic [11:0] OFS_XCMD = 12'h120;
	localparam logic [11:0] OFS_XSTAT = 12'h128;
	// registers of our own: cpu control, cpu status, irq status, irq mask
	localparam logic [11:0] OFS_CPUCTL = 12'h200;
	localparam logic [11:0] OFS_CPUSTAT = 12'h204;
	localparam logic [11:0] OFS_IRQSTAT = 12'h208;
	localparam logic [11:0] OFS_IRQMASK = 12'h20C;
	// field positions
	localparam int BIT_REEVAL = 0;
	localparam int BIT_ERR39 = 7;
	localparam int BIT_GO = 0;
	localparam int BIT_BUSY = 0;
	localparam int BIT_RST_EN = 0;
	localparam int BIT_STATE_EN = 1;
	localparam int BIT_RST_FLAG = 0;
	localparam int BIT_STATE_FLAG = 1;
	// irq status bits: 0 module error, 1 transition done
	localparam int IRQ_ERR = 0;
	localparam int IRQ_DONE = 1;
	// reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [1:0] RST_MASK = 2'h0;
	// cycles per module transition step
	localparam int STEP_CYCLES = 4;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} psic_bus_s;

	typedef struct packed {
		logic stateAltered;
		logic resetAltered;
	} psic_emu_s;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction
endpackage
